// ==== dhi_pkg.sv ====
// dhi_pkg: constants and carrier types of the two-wire host command port.
// assumes: shared by the port module and its testbench; apb data is 32 bits wide.
`default_nettype none

package dhi_pkg;

    ////////////////////////////////////////////////////////////////////////
    // two-wire addressing
    localparam logic [7:0]  I2C_WR_ADDR    = 8'h30;
    localparam logic [7:0]  I2C_RD_ADDR    = 8'h31;
    localparam logic [3:0]  BIT_ACK        = 4'h8;
    localparam logic [1:0]  BYTE_LAST      = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // program ram
    localparam int          PRAM_WORDS     = 1024;
    localparam logic [10:0] PRAM_START     = 11'h000;

    ////////////////////////////////////////////////////////////////////////
    // apb register map (byte addresses)
    localparam logic [7:0]  REG_CTRL       = 8'h00;
    localparam logic [7:0]  REG_STATUS     = 8'h04;
    localparam logic [7:0]  REG_LAST_CMD   = 8'h08;
    localparam logic [7:0]  REG_PRAM_ADDR  = 8'h0C;
    localparam logic [7:0]  REG_PRAM_DATA  = 8'h10;
    localparam logic [7:0]  REG_XFER_CNT   = 8'h14;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0001;
    localparam int          CTRL_EN_BIT    = 0;

    ////////////////////////////////////////////////////////////////////////
    // 24-bit command layout, msb first on the wire
    typedef struct packed {
        logic [15:0] addr;
        logic        unused;
        logic        boot;
        logic        sreset;
        logic        rd;
        logic [3:0]  count;
    } dhi_cmd_t;

    // one runtime write word handed to the dsp core
    typedef struct packed {
        logic [15:0] addr;
        logic [23:0] data;
    } dhi_wword_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_WRITE,
        ST_READ,
        ST_WAIT
    } dhi_state_t;

endpackage : dhi_pkg

`default_nettype wire

// ==== dhi_port.sv ====
// dhi_port: two-wire target port of the dsp host interface, with apb status.
// assumes: scl/sda and the select pin are asynchronous and are synchronised here;
// rd_data_i answers rd_addr_o one cycle after it changes; sda is open drain.
`default_nettype none

module dhi_port
    import dhi_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        reset_n_i,
    input  wire logic        host_if_select_pin_i,
    input  wire logic        host_serial_clock_pin_i,
    input  wire logic        host_serial_data_pin_i,
    output var  logic        host_serial_data_pin_o,
    output var  logic        host_serial_data_pin_oe_o,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output var  logic [31:0] prdata_o,
    output var  logic        pready_o,
    output var  logic        pslverr_o,
    output var  logic        wr_valid_o,
    output var  dhi_wword_t  wr_word_o,
    input  wire logic        wr_ready_i,
    output var  logic [15:0] rd_addr_o,
    input  wire logic [23:0] rd_data_i,
    output var  logic        soft_reset_o,
    output var  logic        boot_active_o
);

    ////////////////////////////////////////////////////////////////////////
    // declarations
    logic [2:0]  scl_s_r, sda_s_r, sel_s_r;
    logic        scl_rise, scl_fall, start_det, stop_det, port_on;
    dhi_state_t  st_r;
    logic [3:0]  bit_cnt_r;
    logic [1:0]  byte_idx_r;
    logic [7:0]  shreg_r;
    logic [15:0] word_acc_r;
    logic [23:0] word_nxt, tx_sh_r;
    dhi_cmd_t    cmd_nxt, last_cmd_r;
    logic        cmd_phase_r, sda_oe_r, byte_fall, ack_ok, words_ok;
    logic        cmd_latch, data_word, buf_push, pram_we, read_end;
    logic        soft_reset_r, first_cmd_r, boot_active_r, rd_pending_r;
    logic [10:0] boot_addr_r;
    logic [3:0]  words_rem_r;
    logic [15:0] wr_addr_r, rd_ptr_r;
    logic [31:0] xfer_cnt_r, ctrl_r, prdata_r;
    logic [9:0]  pram_rd_addr_r;
    logic [15:0] pram_r [PRAM_WORDS];
    dhi_wword_t  out_word_r, skid_word_r, push_word;
    logic        out_valid_r, skid_valid_r, buf_in_ready, buf_pop;
    logic        pready_r, pslverr_r, apb_setup, apb_wr;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_LAST_CMD) ||
                 (a == REG_PRAM_ADDR) || (a == REG_PRAM_DATA) || (a == REG_XFER_CNT);
    endfunction : mapped

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers; stage 0 feeds stage 1 only, edges use stages 1 and 2
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            scl_s_r <= 3'h7;
            sda_s_r <= 3'h7;
            sel_s_r <= 3'h0;
        end else begin
            scl_s_r <= {scl_s_r[1:0], host_serial_clock_pin_i};
            sda_s_r <= {sda_s_r[1:0], host_serial_data_pin_i};
            sel_s_r <= {sel_s_r[1:0], host_if_select_pin_i};
        end
    end

    always_comb begin
        port_on   = sel_s_r[1] && ctrl_r[CTRL_EN_BIT];
        scl_rise  = scl_s_r[1] && !scl_s_r[2];
        scl_fall  = !scl_s_r[1] && scl_s_r[2];
        start_det = scl_s_r[1] && scl_s_r[2] && sda_s_r[2] && !sda_s_r[1];
        stop_det  = scl_s_r[1] && scl_s_r[2] && !sda_s_r[2] && sda_s_r[1];
    end

    ////////////////////////////////////////////////////////////////////////
    // byte decode, taken at the scl fall that follows the eighth bit; read_end at the scl rise of the ack bit
    always_comb begin
        byte_fall = port_on && scl_fall && (bit_cnt_r == BIT_ACK);
        word_nxt  = {word_acc_r, shreg_r};
        cmd_nxt   = dhi_cmd_t'(word_nxt);
        words_ok  = boot_active_r ? !boot_addr_r[10] : (words_rem_r != 4'h0);
        ack_ok    = 1'b0;
        case (st_r)
            ST_ADDR:  ack_ok = (shreg_r == I2C_WR_ADDR) ||
                               ((shreg_r == I2C_RD_ADDR) && rd_pending_r);
            ST_WRITE: ack_ok = cmd_phase_r || (words_ok && ((byte_idx_r != BYTE_LAST) ||
                               boot_active_r || buf_in_ready));
            default:  ack_ok = 1'b0;
        endcase
        cmd_latch = byte_fall && (st_r == ST_WRITE) && cmd_phase_r &&
                    (byte_idx_r == BYTE_LAST);
        data_word = byte_fall && (st_r == ST_WRITE) && !cmd_phase_r &&
                    (byte_idx_r == BYTE_LAST) && ack_ok;
        buf_push  = data_word && !boot_active_r;
        pram_we   = data_word && boot_active_r;
        read_end  = port_on && scl_rise && (st_r == ST_READ) &&
                    (bit_cnt_r == BIT_ACK) && sda_s_r[1];
        push_word = '{addr: wr_addr_r, data: word_nxt};
    end

    ////////////////////////////////////////////////////////////////////////
    // bit level protocol engine
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i || !port_on) begin
            st_r        <= ST_IDLE;
            bit_cnt_r   <= 4'h0;
            byte_idx_r  <= 2'h0;
            shreg_r     <= 8'h00;
            word_acc_r  <= 16'h0000;
            cmd_phase_r <= 1'b0;
            sda_oe_r    <= 1'b0;
            tx_sh_r     <= 24'h000000;
            rd_ptr_r    <= 16'h0000;
        end else if (start_det) begin
            // a repeated start after a refused address simply begins again
            st_r       <= ST_ADDR;
            bit_cnt_r  <= 4'h0;
            byte_idx_r <= 2'h0;
            sda_oe_r   <= 1'b0;
        end else if (stop_det) begin
            st_r     <= ST_IDLE;
            sda_oe_r <= 1'b0;
        end else begin
            if (cmd_latch && cmd_nxt.rd && !cmd_nxt.boot) begin
                rd_ptr_r <= cmd_nxt.addr;
            end
            if (scl_rise && (st_r != ST_IDLE) && (st_r != ST_WAIT)) begin
                if (bit_cnt_r != BIT_ACK) begin
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                    shreg_r   <= {shreg_r[6:0], sda_s_r[1]};
                    if (st_r == ST_READ) begin
                        tx_sh_r <= {tx_sh_r[22:0], 1'b0};
                    end
                end else begin
                    bit_cnt_r <= 4'h0;
                    if (st_r == ST_READ) begin
                        if (sda_s_r[1]) begin
                            st_r <= ST_WAIT;
                        end else if (byte_idx_r == BYTE_LAST) begin
                            byte_idx_r <= 2'h0;
                            tx_sh_r    <= rd_data_i;
                            rd_ptr_r   <= rd_ptr_r + 16'h0001;
                        end else begin
                            byte_idx_r <= byte_idx_r + 2'h1;
                        end
                    end
                end
            end
            if (scl_fall) begin
                if (bit_cnt_r == BIT_ACK) begin
                    sda_oe_r <= ack_ok;
                end else if (st_r == ST_READ) begin
                    sda_oe_r <= !tx_sh_r[23];
                end else begin
                    sda_oe_r <= 1'b0;
                end
            end
            // read bytes are acked by the host, so no refusal applies to them
            if (byte_fall && (st_r != ST_READ)) begin
                if (!ack_ok) begin
                    st_r <= ST_WAIT;
                end else if (st_r == ST_ADDR) begin
                    // a read starts at 3 so that the address ack rise wraps it to byte 0
                    byte_idx_r <= shreg_r[0] ? 2'h3 : 2'h0;
                    if (shreg_r[0]) begin
                        st_r     <= ST_READ;
                        tx_sh_r  <= rd_data_i;
                        rd_ptr_r <= rd_ptr_r + 16'h0001;
                    end else begin
                        st_r        <= ST_WRITE;
                        cmd_phase_r <= 1'b1;
                    end
                end else if (st_r == ST_WRITE) begin
                    word_acc_r <= word_nxt[15:0];
                    if (byte_idx_r == BYTE_LAST) begin
                        byte_idx_r  <= 2'h0;
                        cmd_phase_r <= 1'b0;
                    end else begin
                        byte_idx_r <= byte_idx_r + 2'h1;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command effects: soft reset, boot, read request, write addressing
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            last_cmd_r    <= '0;
            soft_reset_r  <= 1'b0;
            first_cmd_r   <= 1'b1;
            boot_active_r <= 1'b0;
            boot_addr_r   <= PRAM_START;
            rd_pending_r  <= 1'b0;
            words_rem_r   <= 4'h0;
            wr_addr_r     <= 16'h0000;
            xfer_cnt_r    <= 32'h0000_0000;
        end else begin
            if (cmd_latch) begin
                last_cmd_r   <= cmd_nxt;
                soft_reset_r <= cmd_nxt.sreset;
                first_cmd_r  <= 1'b0;
                wr_addr_r    <= cmd_nxt.addr;
                words_rem_r  <= cmd_nxt.rd ? 4'h0 : cmd_nxt.count + 4'h1;
                if (first_cmd_r && cmd_nxt.boot && cmd_nxt.sreset) begin
                    boot_active_r <= 1'b1;
                    boot_addr_r   <= PRAM_START;
                end
                if (cmd_nxt.rd && !cmd_nxt.boot) begin
                    rd_pending_r <= 1'b1;
                end
            end
            if (data_word) begin
                if (boot_active_r) begin
                    boot_addr_r <= boot_addr_r + 11'h001;
                end else begin
                    words_rem_r <= words_rem_r - 4'h1;
                    wr_addr_r   <= wr_addr_r + 16'h0001;
                end
            end
            if (read_end) begin
                rd_pending_r <= 1'b0;
            end
            if (port_on && stop_det) begin
                boot_active_r <= 1'b0;
                if (((st_r == ST_WRITE) && !cmd_phase_r) || read_end) begin
                    xfer_cnt_r <= xfer_cnt_r + 32'h0000_0001;
                end
            end
        end
    end

    // vectors at 000h-003h are simply the first four boot words
    always_ff @(posedge clk_sys_i) begin
        if (pram_we) begin
            pram_r[boot_addr_r[9:0]] <= word_nxt[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // two-entry write buffer; a full buffer refuses the word's last byte
    always_comb begin
        buf_in_ready = !skid_valid_r;
        buf_pop      = out_valid_r && wr_ready_i;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            out_valid_r  <= 1'b0;
            skid_valid_r <= 1'b0;
            out_word_r   <= '0;
            skid_word_r  <= '0;
        end else if (out_valid_r && !buf_pop) begin
            if (buf_push && !skid_valid_r) begin
                skid_word_r  <= push_word;
                skid_valid_r <= 1'b1;
            end
        end else if (skid_valid_r) begin
            out_word_r   <= skid_word_r;
            out_valid_r  <= 1'b1;
            skid_word_r  <= push_word;
            skid_valid_r <= buf_push;
        end else begin
            out_word_r  <= push_word;
            out_valid_r <= buf_push;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb slave, zero wait states: pready rises in the access cycle
    always_comb begin
        apb_setup = psel_i && !penable_i;
        apb_wr    = psel_i && penable_i && pready_r && pwrite_i;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= apb_setup;
            pslverr_r <= apb_setup && !mapped(paddr_i);
            prdata_r  <= 32'h0000_0000;
            if (apb_setup && !pwrite_i) begin
                case (paddr_i)
                    REG_CTRL:      prdata_r <= ctrl_r;
                    REG_STATUS:    prdata_r <= {26'h0, first_cmd_r, skid_valid_r,
                                                rd_pending_r, (st_r != ST_IDLE),
                                                boot_active_r, soft_reset_r};
                    REG_LAST_CMD:  prdata_r <= {8'h00, last_cmd_r};
                    REG_PRAM_ADDR: prdata_r <= {22'h0, pram_rd_addr_r};
                    REG_PRAM_DATA: prdata_r <= {16'h0000, pram_r[pram_rd_addr_r]};
                    REG_XFER_CNT:  prdata_r <= xfer_cnt_r;
                    default:       prdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            ctrl_r         <= CTRL_RESET;
            pram_rd_addr_r <= 10'h000;
        end else if (apb_wr && (paddr_i == REG_CTRL)) begin
            ctrl_r <= {31'h0, pwdata_i[CTRL_EN_BIT]};
        end else if (apb_wr && (paddr_i == REG_PRAM_ADDR)) begin
            pram_rd_addr_r <= pwdata_i[9:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output registers
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            host_serial_data_pin_o <= 1'b0;
            rd_addr_o              <= 16'h0000;
            soft_reset_o           <= 1'b0;
            boot_active_o          <= 1'b0;
        end else begin
            host_serial_data_pin_o <= 1'b0;
            rd_addr_o              <= rd_ptr_r;
            soft_reset_o           <= soft_reset_r;
            boot_active_o          <= boot_active_r;
        end
    end

    always_comb begin
        host_serial_data_pin_oe_o = sda_oe_r;
        wr_valid_o                = out_valid_r;
        wr_word_o                 = out_word_r;
        prdata_o                  = prdata_r;
        pready_o                  = pready_r;
        pslverr_o                 = pslverr_r;
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_addr_ack;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        byte_fall && (st_r == ST_ADDR) && (shreg_r != I2C_WR_ADDR) &&
        (shreg_r != I2C_RD_ADDR) |=> !sda_oe_r && (st_r == ST_WAIT);
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("foreign address acked");

    property p_word_limit;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        buf_push |-> (words_rem_r != 4'h0) ##1 (words_rem_r == $past(words_rem_r) - 4'h1);
    endproperty
    a_word_limit: assert property (p_word_limit) else $error("word beyond count");

    property p_read_release;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        read_end |=> (st_r == ST_WAIT) && !rd_pending_r ##1 !sda_oe_r;
    endproperty
    a_read_release: assert property (p_read_release) else $error("sda not released");

    property p_boot_start;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        $rose(boot_active_r) |-> (boot_addr_r == PRAM_START) && $past(first_cmd_r) &&
                                 last_cmd_r.boot && last_cmd_r.sreset;
    endproperty
    a_boot_start: assert property (p_boot_start) else $error("bad boot start");

    property p_boot_step;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        pram_we |=> (boot_addr_r == $past(boot_addr_r) + 11'h001);
    endproperty
    a_boot_step: assert property (p_boot_step) else $error("boot address step");

    property p_boot_end;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        port_on && stop_det && boot_active_r |=> !boot_active_r ##1 !boot_active_o;
    endproperty
    a_boot_end: assert property (p_boot_end) else $error("boot not ended");

    property p_soft_reset;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        cmd_latch |=> (soft_reset_r == last_cmd_r.sreset) ##1 (soft_reset_o == soft_reset_r);
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset mismatch");

    property p_count;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        cmd_latch && !cmd_nxt.rd |=> (words_rem_r == last_cmd_r.count + 4'h1);
    endproperty
    a_count: assert property (p_count) else $error("word count decode");

    property p_select;
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        !sel_s_r[1] |=> (st_r == ST_IDLE) && !sda_oe_r;
    endproperty
    a_select: assert property (p_select) else $error("active while deselected");

endmodule : dhi_port

`default_nettype wire

// ==== dhi_host.sv ====
// dhi_host: behavioural two-wire controller standing in for the host
// assumes: sda_i is the resolved open-drain wire with a pull-up
`default_nettype none
module dhi_host (
    output var  logic scl_o,
    output var  logic sda_o,
    input  wire logic sda_i
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // odd first delay keeps scl out of phase with the system clock
    task automatic start;
        #57 sda_o = 1'b1;
        #50 scl_o = 1'b1;
        #100 sda_o = 1'b0;
        #100 scl_o = 1'b0;
    endtask : start
    task automatic stop;
        #50 sda_o = 1'b0;
        #50 scl_o = 1'b1;
        #100 sda_o = 1'b1;
        #100;
    endtask : stop
    task automatic xbit(input logic b, output logic r);
        #50 sda_o = b;
        #50 scl_o = 1'b1;
        #50 r = sda_i;
        #50 scl_o = 1'b0;
    endtask : xbit
    task automatic wbyte(input logic [7:0] b, output logic a);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xbit(b[i], r);
        end
        xbit(1'b1, a);
    endtask : wbyte
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xbit(1'b1, r);
            d[i] = r;
        end
        xbit(last, r);
    endtask : rbyte
    // one sample period between transactions
    task automatic gap;
        #32000;
    endtask : gap
endmodule : dhi_host
`default_nettype wire

// ==== test_dsp_host_i2c_command_port.sv ====
// test_dsp_host_i2c_command_port: apb and two-wire checks of dhi_port
// assumes: dhi_host drives the bus; sda has a pull-up
`default_nettype none
module test_dsp_host_i2c_command_port
    import dhi_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_sys, scl, host_sda, dev_sda, dev_oe, pready, pslverr;
    logic        reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sel = 1'b1;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q, x0;
    logic        wr_valid, wr_ready = 1'b0, soft_rst, boot_act, a, e;
    logic [15:0] rd_addr;
    logic [23:0] rd_data = 24'h0;
    logic [31:0] ak;
    logic [7:0]  b;
    logic [47:0] rdat;
    dhi_wword_t  wr_word;
    wire logic   sda = (dev_oe ? dev_sda : 1'b1) & host_sda;
    int          error_cnt = 0, tests_run = 0, cyc = 0, n;
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    dhi_port dut (.clk_sys_i(clk_sys), .reset_n_i(reset_n), .host_if_select_pin_i(sel),
        .host_serial_clock_pin_i(scl), .host_serial_data_pin_i(sda),
        .host_serial_data_pin_o(dev_sda), .host_serial_data_pin_oe_o(dev_oe),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .wr_valid_o(wr_valid), .wr_word_o(wr_word), .wr_ready_i(wr_ready),
        .rd_addr_o(rd_addr), .rd_data_i(rd_data), .soft_reset_o(soft_rst),
        .boot_active_o(boot_act));
    dhi_host u_host (.scl_o(scl), .sda_o(host_sda), .sda_i(sda));
    always @(posedge clk_sys) begin
        rd_data <= {8'h5A, rd_addr};
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt++;
            results();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] x);
        tests_run++;
        if (s !== x) begin
            error_cnt++;
            $display("[FAIL] %s exp %h seen %h", nm, x, s);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= ad;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input string nm, input logic [7:0] ad, input logic [31:0] m, x);
        apb(1'b0, ad, 32'h0);
        chk(nm, {e, q & m}, {1'b0, x});
    endtask : rd
    // command word plus nw data words from w0 upward; ack bits gathered in ak
    task automatic frame(input logic [23:0] cmd, input int nw, input logic [23:0] w0);
        logic [23:0] w;
        ak = 32'h0;
        u_host.start();
        u_host.wbyte(I2C_WR_ADDR, a);
        ak = {ak[30:0], a};
        for (int k = 0; k <= nw; k++) begin
            w = (k == 0) ? cmd : w0 + 24'(k - 1);
            for (int j = 2; j >= 0; j--) begin
                u_host.wbyte(w[8*j +: 8], a);
                ak = {ak[30:0], a};
            end
        end
        u_host.stop();
        #1000;
    endtask : frame
    task automatic results;
        if (error_cnt == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd("ctrl", REG_CTRL, 32'h1, 32'h1);
        rd("status", REG_STATUS, 32'h1F, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped", {e, q}, {1'b1, 32'h0});
        apb(1'b1, REG_STATUS, 32'h1F);
        rd("status_ro", REG_STATUS, 32'h1F, 32'h0);
        apb(1'b1, REG_PRAM_ADDR, 32'hFFF);
        rd("pram_addr", REG_PRAM_ADDR, 32'hFFFF_FFFF, 32'h3FF);
        frame(24'h000060, 5, 24'hA51000);
        chk("boot", {ak, soft_rst, boot_act}, 2'b10);
        u_host.gap();
        for (int k = 0; k < 5; k++) begin
            apb(1'b1, REG_PRAM_ADDR, 32'(k));
            rd("pram", REG_PRAM_DATA, 32'hFFFF_FFFF, 32'h1000 + k);
        end
        apb(1'b0, REG_XFER_CNT, 32'h0);
        x0 = q;
        frame(24'h000000, 0, 24'h0);
        chk("run", {ak, soft_rst}, 0);
        rd("xfer", REG_XFER_CNT, 32'hFFFF_FFFF, x0 + 1);
        u_host.gap();
        u_host.start();
        u_host.wbyte(8'h32, a);
        chk("bad_addr", a, 1'b1);
        u_host.start();
        u_host.wbyte(I2C_WR_ADDR, a);
        chk("retry", a, 1'b0);
        u_host.stop();
        frame({16'h1234, 8'h02}, 3, 24'hABC000);
        chk("full_nak", ak, 32'h1);
        rd("full", REG_STATUS, 32'h10, 32'h10);
        @(posedge clk_sys);
        wr_ready <= 1'b1;
        n = 0;
        for (int t = 0; t < 100 && n < 2; t++) begin
            @(posedge clk_sys);
            if (wr_valid === 1'b1) begin
                chk("wr_word", wr_word, {16'(16'h1234 + n), 24'(24'hABC000 + n)});
                n++;
            end
        end
        @(posedge clk_sys);
        chk("drained", {n[1:0], wr_valid}, 3'b100);
        u_host.gap();
        frame({16'h0040, 8'h11}, 0, 24'h0);
        rd("rd_pend", REG_STATUS, 32'h8, 32'h8);
        u_host.gap();
        u_host.start();
        u_host.wbyte(I2C_RD_ADDR, a);
        for (int k = 0; k < 6; k++) begin
            u_host.rbyte(k == 5, b);
            rdat = {rdat[39:0], b};
        end
        u_host.stop();
        chk("rd_data", {ak[3:0], a, rdat}, {5'h00, 24'h5A0040, 24'h5A0041});
        chk("released", dev_oe, 1'b0);
        rd("rd_done", REG_STATUS, 32'h8, 32'h0);
        u_host.start();
        u_host.wbyte(I2C_RD_ADDR, a);
        u_host.stop();
        chk("rd_nopend", a, 1'b1);
        @(posedge clk_sys);
        sel <= 1'b0;
        u_host.start();
        u_host.wbyte(I2C_WR_ADDR, a);
        u_host.stop();
        chk("deselect", a, 1'b1);
        @(posedge clk_sys);
        sel <= 1'b1;
        apb(1'b1, REG_CTRL, 32'h0);
        rd("ctrl_off", REG_CTRL, 32'hFFFF_FFFF, 32'h0);
        u_host.start();
        u_host.wbyte(I2C_WR_ADDR, a);
        u_host.stop();
        chk("disabled", a, 1'b1);
        apb(1'b1, REG_CTRL, 32'h1);
        rd("ctrl_on", REG_CTRL, 32'hFFFF_FFFF, 32'h1);
        frame(24'h000020, 0, 24'h0);
        chk("sreset", {ak, soft_rst}, 1);
        results();
    end
endmodule : test_dsp_host_i2c_command_port
`default_nettype wire
